// [hw/cbn_pkg.sv]
// Shared constants and types for the control bus node and host ends
package cbn_pkg;

   // Timing, all counts derived from the system clock period
   localparam int  CLK_NS        = 4;
   localparam int  BUS_HALF_NS   = 40;
   localparam int  HALF_CYC      = (BUS_HALF_NS + CLK_NS - 1) / CLK_NS;
   localparam int  SYNC_PERIODS  = 8;
   localparam int  SYNC_CYC      = SYNC_PERIODS * 2 * HALF_CYC;
   localparam int  SYNC_DET_NS   = 320;
   localparam int  SYNC_DET_CYC  = (SYNC_DET_NS + CLK_NS - 1) / CLK_NS;
   localparam real CLK_LOSS_MS   = 1.5;
   localparam int  CLK_LOSS_CYC  = int'(CLK_LOSS_MS * 1.0e6) / CLK_NS;

   // Frame layout
   localparam int  FRAME_MIN     = 15;
   localparam int  FRAME_MAX     = 255;
   localparam int  CHAN_SLOTS    = 4;
   localparam int  DEB_FRAMES    = 3;
   localparam int  NODE_IN_N     = 8;
   localparam int  NODE_OUT_N    = 8;

   // Host register map (byte addresses)
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_LEN      = 8'h04;
   localparam logic [7:0] REG_CHAN     = 8'h08;
   localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
   localparam logic [7:0] REG_IRQ_MASK = 8'h10;
   localparam logic [7:0] REG_STATUS   = 8'h14;
   localparam logic [1:0] REGION_OUT   = 2'h1;
   localparam logic [1:0] REGION_IN    = 2'h2;

   // Field positions and reset values
   localparam int  CTRL_RUN      = 0;
   localparam int  CTRL_MS       = 1;
   localparam int  CTRL_PT       = 2;
   localparam int  CTRL_MUX      = 3;
   localparam int  IRQ_FRAME     = 0;
   localparam int  IRQ_CHANGE    = 1;
   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam logic [7:0] LEN_RST  = 8'h0F;

   typedef enum logic [1:0] {H_IDLE, H_SYNC, H_LOW, H_HIGH} cbn_hstate_t;

endpackage

// [hw/cbn_bus_if.sv]
// Two-wire control bus link: clock driven by the host, open-drain data line
`timescale 1ns/1ns
`default_nettype none
interface cbn_bus_if;
   logic bus_clk;
   logic host_dat_o;
   logic host_dat_oe;
   logic node_dat_o;
   logic node_dat_oe;
   logic data_line;

   // Pulled high; any enabled driver low pulls it down
   assign data_line = ~((host_dat_oe & ~host_dat_o) | (node_dat_oe & ~node_dat_o));

   modport host (output bus_clk, output host_dat_o, output host_dat_oe, input data_line);
   modport node (input bus_clk, output node_dat_o, output node_dat_oe, input data_line);
endinterface
`default_nettype wire

// [hw/cbn_debounce.sv]
// Per-bit frame debounce for a received discrete output
`timescale 1ns/1ns
`default_nettype none
module cbn_debounce
   import cbn_pkg::*;
(
   input  wire logic clk_in,       // System clock
   input  wire logic reset_n_in,   // Sync reset, active low
   input  wire logic clear_in,     // Force default value
   input  wire logic en_in,        // Debounce enabled
   input  wire logic tick_in,      // Valid frame ended
   input  wire logic sample_in,    // Value received this frame
   output logic      value_out     // Debounced value
);
   typedef struct packed {
      logic       val;
      logic [1:0] cnt;
   } cbn_deb_t;

   cbn_deb_t s;
   cbn_deb_t next_s;

   always_comb begin
      next_s = s;
      if (clear_in) begin
         next_s = '0;                                      // R3
      end else if (tick_in) begin
         if (!en_in || sample_in == s.val) begin
            next_s.val = sample_in;
            next_s.cnt = 2'h0;
         end else if (s.cnt == 2'(DEB_FRAMES - 1)) begin
            next_s.val = sample_in;                        // R4
            next_s.cnt = 2'h0;
         end else begin
            next_s.cnt = s.cnt + 2'h1;                     // R4
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign value_out = s.val;
endmodule // cbn_debounce
`default_nettype wire

// [hw/cbn_node.sv]
// I/O node end of the control bus: address counting, drive, sample, clock loss
//
// Notes on behaviour
// R1 - Frames bounded by sync, 15 to 255 addresses
// R2 - Low data line means 1, high 0
// R3 - Clock loss drives outputs to 0
// R4 - Debounce: change after consecutive equal frames
// R5 - Health address always driven with 1
// R6 - Master/slave: input pulse, then output pulse
// R7 - Respond only in frames of own channel
// R8 - Host pass-through resends inputs as outputs
// R9 - Multi-bit signal uses consecutive addresses
// R10 - Sync of 8 periods resets address counter
// R11 - No clock edge for 1.5 ms is loss
// R12 - Peer mode: one pulse, shared sample
// R13 - Lowest address carries least significant bit
// R14 - Counter advances per slot, drive on match
`timescale 1ns/1ns
`default_nettype none
module cbn_node
   import cbn_pkg::*;
#(
   parameter int LOSS_CYC = CLK_LOSS_CYC
)(
   input  wire logic                  clk_in,            // System clock
   input  wire logic                  reset_n_in,        // Sync reset, active low
   cbn_bus_if.node                    bus,               // Bus link
   input  wire logic                  cfg_ms_in,         // Master/slave mode
   input  wire logic                  cfg_mux_in,        // Channel multiplexing on
   input  wire logic [3:0]            cfg_chan_in,       // Own channel
   input  wire logic                  cfg_debounce_in,   // Debounce outputs
   input  wire logic                  cfg_health_en_in,  // Health bit offered
   input  wire logic [7:0]            cfg_health_addr_in,// Health address
   input  wire logic [7:0]            cfg_in_base_in,    // First input address
   input  wire logic [7:0]            cfg_out_base_in,   // First output address
   input  wire logic [NODE_IN_N-1:0]  inputs_in,         // External inputs
   output logic      [NODE_OUT_N-1:0] outputs_out,       // Received outputs
   output logic                       clock_lost_out,    // Clock loss seen
   output logic      [7:0]            frame_len_out      // Length of last valid frame
);
   typedef struct packed {
      logic                  c1;
      logic                  c2;
      logic                  c3;
      logic                  d1;
      logic                  d2;
      logic [NODE_IN_N-1:0]  i1;
      logic [NODE_IN_N-1:0]  i2;
      logic [18:0]           idle;
      logic                  lost;
      logic                  in_frame;
      logic [7:0]            addr;
      logic                  phase;
      logic                  chan_ok;
      logic [3:0]            rx_chan;
      logic [NODE_OUT_N-1:0] rx_out;
      logic                  tick;
      logic                  drv;
      logic [7:0]            flen;
   } cbn_node_t;

   cbn_node_t s;
   cbn_node_t next_s;

   logic                  edge_seen;
   logic                  rise;
   logic                  rx_bit;
   logic                  in_pulse;
   logic                  out_pulse;
   logic                  chan_slot;
   logic [7:0]            rel_in;
   logic [7:0]            rel_out;
   logic                  drive_v;
   logic [NODE_OUT_N-1:0] deb_val;

   localparam logic [18:0] LOSS_W    = 19'(LOSS_CYC);
   localparam logic [18:0] SYNC_W    = 19'(SYNC_DET_CYC);
   localparam logic [7:0]  FMIN_W    = 8'(FRAME_MIN);
   localparam logic [7:0]  CSLOT_W   = 8'(CHAN_SLOTS);
   localparam logic [7:0]  IN_N_W    = 8'(NODE_IN_N);
   localparam logic [7:0]  OUT_N_W   = 8'(NODE_OUT_N);

   // Edges are judged on the second and third stages only
   assign edge_seen = s.c2 ^ s.c3;
   assign rise      = s.c2 & ~s.c3;
   assign rx_bit    = ~s.d2;                                 // R2
   assign in_pulse  = !cfg_ms_in || !s.phase;                // R6 R12
   assign out_pulse = !cfg_ms_in || s.phase;                 // R6 R12
   assign chan_slot = cfg_mux_in && (s.addr < CSLOT_W);
   assign rel_in    = s.addr - cfg_in_base_in;               // R9 R13
   assign rel_out   = s.addr - cfg_out_base_in;              // R9 R13

   // Value this node puts on the line for the current slot
   always_comb begin
      drive_v = 1'b0;
      if (s.in_frame && !s.lost && in_pulse && s.chan_ok && !chan_slot) begin   // R7 R14
         if (cfg_health_en_in && s.addr == cfg_health_addr_in) begin
            drive_v = 1'b1;                                  // R5
         end else if (rel_in < IN_N_W) begin
            drive_v = s.i2[rel_in[2:0]];                     // R14
         end
      end
   end

   always_comb begin
      next_s      = s;
      next_s.c1   = bus.bus_clk;
      next_s.c2   = s.c1;
      next_s.c3   = s.c2;
      next_s.d1   = bus.data_line;
      next_s.d2   = s.d1;
      next_s.i1   = inputs_in;
      next_s.i2   = s.i1;
      next_s.tick = 1'b0;
      // New data only while the clock is low; release at once so the host never overlaps
      next_s.drv  = (!drive_v || (!s.c2 && !s.c3)) ? drive_v : s.drv;   // R6

      // Idle timer: sync pause first, clock loss later
      if (edge_seen) begin
         next_s.idle = '0;
         next_s.lost = 1'b0;
      end else if (s.idle != LOSS_W) begin
         next_s.idle = s.idle + 19'h00001;
         if (s.idle == LOSS_W - 19'h00001) begin
            next_s.lost = 1'b1;                              // R11
         end
      end

      if (!edge_seen && s.idle == SYNC_W - 19'h00001) begin
         // Sync pause: close the frame and restart counting
         if (s.in_frame && !s.lost && s.addr >= FMIN_W && s.chan_ok) begin   // R1 R7
            next_s.tick = 1'b1;
            next_s.flen = s.addr;
         end
         next_s.in_frame = 1'b1;
         next_s.addr     = 8'h00;                            // R10
         next_s.phase    = 1'b0;
         next_s.chan_ok  = !cfg_mux_in;
         next_s.rx_chan  = 4'h0;
      end else if (rise && s.in_frame) begin
         if (out_pulse) begin
            if (chan_slot) begin
               next_s.rx_chan[s.addr[1:0]] = rx_bit;         // R7 R13
               if (s.addr == CSLOT_W - 8'h01) begin
                  next_s.chan_ok = ({rx_bit, s.rx_chan[2:0]} == cfg_chan_in);  // R7
               end
            end else if (s.chan_ok && rel_out < OUT_N_W) begin
               next_s.rx_out[rel_out[2:0]] = rx_bit;         // R9 R14
            end
         end
         // Address advances once per slot; two pulses per slot in master/slave
         if (cfg_ms_in && !s.phase) begin
            next_s.phase = 1'b1;                             // R6
         end else begin
            next_s.phase = 1'b0;
            if (s.addr != 8'(FRAME_MAX)) begin
               next_s.addr = s.addr + 8'h01;                 // R14
            end
         end
      end

      // After loss the frame state is stale until the next sync
      if (s.lost) begin
         next_s.in_frame = 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         s      <= '0;
         s.lost <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NODE_OUT_N; g++) begin : g_deb
         cbn_debounce u_deb (
            .clk_in     (clk_in),
            .reset_n_in (reset_n_in),
            .clear_in   (s.lost),                            // R3 R11
            .en_in      (cfg_debounce_in),
            .tick_in    (s.tick),
            .sample_in  (s.rx_out[g]),
            .value_out  (deb_val[g])
         );
      end
   endgenerate

   // Open drain: pull low to send a one
   assign bus.node_dat_o  = 1'b0;
   assign bus.node_dat_oe = s.drv;                           // R2
   assign outputs_out     = deb_val;
   assign clock_lost_out  = s.lost;
   assign frame_len_out   = s.flen;
endmodule // cbn_node
`default_nettype wire

// [hw/cbn_host.sv]
// Host controller end: bus clock source, frame sequencing, software registers
`timescale 1ns/1ns
`default_nettype none
module cbn_host
   import cbn_pkg::*;
(
   input  wire logic        clk_in,       // System clock
   input  wire logic        reset_n_in,   // Sync reset, active low
   cbn_bus_if.host          bus,          // Bus link
   input  wire logic [7:0]  sw_addr_in,   // Register byte address
   input  wire logic [31:0] sw_wdata_in,  // Write data
   input  wire logic        sw_wr_in,     // Write strobe
   input  wire logic        sw_rd_in,     // Read strobe
   output logic      [31:0] sw_rdata_out, // Read data, cycle after strobe
   output logic             irq_out       // Level interrupt
);
   typedef struct packed {
      cbn_hstate_t  st;
      logic [7:0]   cnt;
      logic [7:0]   addr;
      logic         phase;
      logic         clk;
      logic         drv;
      logic         d1;
      logic         d2;
      logic [3:0]   ctrl;
      logic [7:0]   len;
      logic [3:0]   chan;
      logic         ms;
      logic         pt;
      logic         mux;
      logic [7:0]   flen;
      logic [3:0]   fchan;
      logic [255:0] out_bits;
      logic [255:0] in_bits;
      logic [1:0]   stat;
      logic [1:0]   mask;
      logic [31:0]  rdata;
   } cbn_host_t;

   cbn_host_t s;
   cbn_host_t next_s;

   logic       rx_bit;
   logic       out_pulse;
   logic       drive_v;
   logic [1:0] ev;
   logic [3:0] w;

   localparam logic [7:0] HALF_W = 8'(HALF_CYC - 1);
   localparam logic [7:0] SYNC_W = 8'(SYNC_CYC - 1);

   assign rx_bit    = ~s.d2;                                 // R2
   assign out_pulse = !s.ms || s.phase;
   assign w         = sw_addr_in[5:2];

   // Host drives channel slots, and in master/slave the output pulse
   always_comb begin
      drive_v = 1'b0;
      if ((s.st == H_LOW || s.st == H_HIGH) && out_pulse) begin
         if (s.mux && s.addr < 8'(CHAN_SLOTS)) begin
            drive_v = s.fchan[s.addr[1:0]];                  // R7
         end else if (s.ms) begin
            drive_v = s.pt ? s.in_bits[s.addr] : s.out_bits[s.addr];   // R6 R8
         end
      end
   end

   always_comb begin
      next_s       = s;
      next_s.d1    = bus.data_line;
      next_s.d2    = s.d1;
      next_s.drv   = drive_v;
      next_s.rdata = 32'h0000_0000;
      ev           = 2'b00;

      if (sw_wr_in) begin
         if (sw_addr_in == REG_CTRL) begin
            next_s.ctrl = sw_wdata_in[3:0];
         end else if (sw_addr_in == REG_LEN) begin
            next_s.len = (sw_wdata_in[7:0] < 8'(FRAME_MIN)) ? 8'(FRAME_MIN) : sw_wdata_in[7:0];
         end else if (sw_addr_in == REG_CHAN) begin
            next_s.chan = sw_wdata_in[3:0];
         end else if (sw_addr_in == REG_IRQ_STAT) begin
            next_s.stat = s.stat & ~sw_wdata_in[1:0];
         end else if (sw_addr_in == REG_IRQ_MASK) begin
            next_s.mask = sw_wdata_in[1:0];
         end else if (sw_addr_in[7:6] == REGION_OUT) begin
            next_s.out_bits[{w, 4'h0} +: 16] = sw_wdata_in[15:0];
         end
      end

      if (sw_rd_in) begin
         if (sw_addr_in == REG_CTRL) begin
            next_s.rdata = {28'h0000000, s.ctrl};
         end else if (sw_addr_in == REG_LEN) begin
            next_s.rdata = {24'h000000, s.len};
         end else if (sw_addr_in == REG_CHAN) begin
            next_s.rdata = {28'h0000000, s.chan};
         end else if (sw_addr_in == REG_IRQ_STAT) begin
            next_s.rdata = {30'h00000000, s.stat};
         end else if (sw_addr_in == REG_IRQ_MASK) begin
            next_s.rdata = {30'h00000000, s.mask};
         end else if (sw_addr_in == REG_STATUS) begin
            next_s.rdata = {16'h0000, s.addr, 7'h00, s.st != H_IDLE};
         end else if (sw_addr_in[7:6] == REGION_OUT) begin
            next_s.rdata = {16'h0000, s.out_bits[{w, 4'h0} +: 16]};
         end else if (sw_addr_in[7:6] == REGION_IN) begin
            next_s.rdata = {16'h0000, s.in_bits[{w, 4'h0} +: 16]};    // R13
         end
      end

      unique case (s.st)
         H_IDLE: begin
            next_s.clk = 1'b0;
            next_s.cnt = 8'h00;
            if (s.ctrl[CTRL_RUN]) begin
               next_s.st = H_SYNC;
            end
         end
         H_SYNC: begin
            next_s.clk = 1'b0;
            next_s.cnt = s.cnt + 8'h01;
            if (s.cnt == SYNC_W) begin                       // R10
               next_s.cnt = 8'h00;
               if (s.ctrl[CTRL_RUN]) begin
                  next_s.st    = H_LOW;
                  next_s.addr  = 8'h00;
                  next_s.phase = 1'b0;
                  next_s.ms    = s.ctrl[CTRL_MS];
                  next_s.pt    = s.ctrl[CTRL_PT];
                  next_s.mux   = s.ctrl[CTRL_MUX];
                  next_s.flen  = s.len;
                  next_s.fchan = s.chan;
               end else begin
                  next_s.st = H_IDLE;
               end
            end
         end
         H_LOW: begin
            next_s.clk = 1'b0;
            next_s.cnt = s.cnt + 8'h01;
            if (s.cnt == HALF_W) begin
               next_s.cnt = 8'h00;
               next_s.clk = 1'b1;
               next_s.st  = H_HIGH;
               if (!s.ms || !s.phase) begin                  // R12
                  next_s.in_bits[s.addr] = rx_bit;
                  ev[IRQ_CHANGE] = (rx_bit != s.in_bits[s.addr]);
               end
            end
         end
         H_HIGH: begin
            next_s.clk = 1'b1;
            next_s.cnt = s.cnt + 8'h01;
            if (s.cnt == HALF_W) begin
               next_s.cnt = 8'h00;
               next_s.clk = 1'b0;
               if (s.ms && !s.phase) begin
                  next_s.phase = 1'b1;                       // R6
                  next_s.st    = H_LOW;
               end else begin
                  next_s.phase = 1'b0;
                  if (s.addr == s.flen - 8'h01) begin        // R1
                     next_s.st      = H_SYNC;
                     ev[IRQ_FRAME] = 1'b1;
                  end else begin
                     next_s.addr = s.addr + 8'h01;
                     next_s.st   = H_LOW;
                  end
               end
            end
         end
      endcase

      // Hardware set wins over a same-cycle clear
      next_s.stat = next_s.stat | ev;
   end

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         s      <= '0;
         s.st   <= H_IDLE;
         s.ctrl <= CTRL_RST;
         s.len  <= LEN_RST;
         s.flen <= LEN_RST;
      end else begin
         s <= next_s;
      end
   end

   assign bus.bus_clk     = s.clk;
   assign bus.host_dat_o  = 1'b0;
   assign bus.host_dat_oe = s.drv;
   assign sw_rdata_out    = s.rdata;
   assign irq_out         = |(s.stat & s.mask);
endmodule // cbn_host
`default_nettype wire

// [dv/cbn_bus_properties.sv]
// Bus-level checks between the host end and the node end
`timescale 1ns/1ns
`default_nettype none
module cbn_bus_properties
   import cbn_pkg::*;
(
   input  wire logic clk_in,       // System clock
   input  wire logic reset_n_in,   // Sync reset, active low
   input  wire logic bus_clk,      // Bus clock
   input  wire logic host_dat_o,   // Host data value
   input  wire logic host_dat_oe,  // Host pulls line low
   input  wire logic node_dat_o,   // Node data value
   input  wire logic node_dat_oe,  // Node pulls line low
   input  wire logic data_line     // Resolved data line
);
   logic [11:0] low_cnt;
   logic [9:0]  rise_cnt;
   logic        prev_clk;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);

   // Saturates so a halted bus never wraps back into slot range
   always_ff @(posedge clk_in) begin
      prev_clk <= bus_clk;
      if (!reset_n_in || bus_clk) begin
         low_cnt <= 12'h000;
      end else if (low_cnt != 12'hFFF) begin
         low_cnt <= low_cnt + 12'h001;
      end
      if (!reset_n_in || low_cnt == 12'h079) begin
         rise_cnt <= 10'h000;
      end else if (bus_clk && !prev_clk) begin
         rise_cnt <= rise_cnt + 10'h001;
      end
   end

   chk_open_drain: assert property (!host_dat_o && !node_dat_o)
      else $error("data driven high instead of released");
   chk_one_driver: assert property (!(host_dat_oe && node_dat_oe))
      else $error("host and node drive the same pulse");
   chk_high_len: assert property ($rose(bus_clk) |=> bus_clk[*8] ##1 bus_clk ##1 !bus_clk)
      else $error("bus clock high phase not ten cycles");
   chk_low_len: assert property ($rose(bus_clk) |->
      (low_cnt == 12'h00A || low_cnt >= 12'(SYNC_CYC)))
      else $error("clock low phase neither slot nor sync pause");
   chk_sync_quiet: assert property (low_cnt > 12'h00C && low_cnt < 12'h050 |->
      !host_dat_oe && !node_dat_oe)
      else $error("data driven during sync pause");
   chk_frame_size: assert property (low_cnt == 12'h078 && rise_cnt != 10'h000 |->
      rise_cnt >= FRAME_MIN && rise_cnt <= 2 * FRAME_MAX)
      else $error("frame pulse count out of range");
   chk_host_hold: assert property (bus_clk && $past(bus_clk) |-> $stable(host_dat_oe))
      else $error("host drive changed in high phase");
   chk_node_hold: assert property ($rose(bus_clk) |-> ##7 $stable(node_dat_oe)[*3])
      else $error("node drive changed near falling edge");

   cover property ($rose(node_dat_oe));
   cover property ($rose(host_dat_oe));
   cover property (low_cnt == 12'h078 && rise_cnt >= 10'h03C);
   cover property (!data_line);
endmodule // cbn_bus_properties
`default_nettype wire

// [dv/control_bus_io_node_tb_top.sv]
// Testbench: host end and node end joined over the bus link
`timescale 1ns/1ns
`default_nettype none
module control_bus_io_node_tb_top
   import cbn_pkg::*;
;
   localparam int LOSS = 400;
   logic        clk_in = 1'b0;
   logic        reset_n_in;
   logic [7:0]  sw_addr;
   logic [31:0] sw_wdata;
   logic        sw_wr;
   logic        sw_rd;
   logic [31:0] sw_rdata;
   logic        irq;
   logic        cfg_ms;
   logic        cfg_mux;
   logic        cfg_deb;
   logic        cfg_hen;
   logic [3:0]  cfg_chan;
   logic [7:0]  cfg_haddr;
   logic [7:0]  cfg_inb;
   logic [7:0]  cfg_outb;
   logic [7:0]  ins;
   logic [7:0]  outs;
   logic [7:0]  flen;
   logic        lost;
   logic [31:0] rv;
   int          bad_count;
   int          n_compared;

   cbn_bus_if u_cbn_bus_if ();

   cbn_host u_cbn_host (.clk_in(clk_in), .reset_n_in(reset_n_in), .bus(u_cbn_bus_if),
      .sw_addr_in(sw_addr), .sw_wdata_in(sw_wdata), .sw_wr_in(sw_wr), .sw_rd_in(sw_rd),
      .sw_rdata_out(sw_rdata), .irq_out(irq));

   cbn_node #(.LOSS_CYC(LOSS)) u_cbn_node (.clk_in(clk_in), .reset_n_in(reset_n_in),
      .bus(u_cbn_bus_if), .cfg_ms_in(cfg_ms), .cfg_mux_in(cfg_mux), .cfg_chan_in(cfg_chan),
      .cfg_debounce_in(cfg_deb), .cfg_health_en_in(cfg_hen), .cfg_health_addr_in(cfg_haddr),
      .cfg_in_base_in(cfg_inb), .cfg_out_base_in(cfg_outb), .inputs_in(ins),
      .outputs_out(outs), .clock_lost_out(lost), .frame_len_out(flen));

   cbn_bus_properties u_cbn_bus_properties (.clk_in(clk_in), .reset_n_in(reset_n_in),
      .bus_clk(u_cbn_bus_if.bus_clk), .host_dat_o(u_cbn_bus_if.host_dat_o),
      .host_dat_oe(u_cbn_bus_if.host_dat_oe), .node_dat_o(u_cbn_bus_if.node_dat_o),
      .node_dat_oe(u_cbn_bus_if.node_dat_oe), .data_line(u_cbn_bus_if.data_line));

   always #2 clk_in = ~clk_in;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("compared=%0d mismatches=%0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      sw_addr  <= a;
      sw_wdata <= d;
      sw_wr    <= 1'b1;
      @(posedge clk_in);
      sw_wr <= 1'b0;
   endtask

   // Data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_in);
      sw_addr <= a;
      sw_rd   <= 1'b1;
      @(posedge clk_in);
      sw_rd <= 1'b0;
      #1;
      d = sw_rdata;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd(a, d);
      check(d, exp);
   endtask

   // Waits on the frame-done interrupt, then clears it
   task automatic wait_frame(input int n);
      int k;
      repeat (n) begin
         k = 0;
         while (irq !== 1'b1 && k < 4000) begin
            @(posedge clk_in);
            k++;
         end
         if (irq !== 1'b1) begin
            bad_count++;
            results();
         end else begin
            wr(REG_IRQ_STAT, 32'h0000_0001);
            #1;
         end
      end
   endtask

   initial begin
      reset_n_in = 1'b0;
      sw_addr = 8'h00;
      sw_wdata = 32'h0;
      sw_wr = 1'b0;
      sw_rd = 1'b0;
      {cfg_ms, cfg_mux, cfg_deb} = 3'h0;
      cfg_hen = 1'b1;
      cfg_chan = 4'h5;
      cfg_haddr = 8'h1E;
      cfg_inb = 8'h10;
      cfg_outb = 8'h00;
      ins = 8'hC3;
      bad_count = 0;
      n_compared = 0;
      repeat (12) @(posedge clk_in);
      reset_n_in <= 1'b1;
      check({31'h0, lost}, 32'h1);
      rdc(REG_LEN, 32'h0000_000F);
      rdc(8'h3C, 32'h0);
      wr(REG_LEN, 32'h0000_0005);
      rdc(REG_LEN, 32'h0000_000F);
      wr(REG_LEN, 32'h0000_0020);
      wr(REG_IRQ_MASK, 32'h0000_0001);
      wr(REG_CTRL, 32'h0000_0001);
      wait_frame(2);
      check({31'h0, irq}, 32'h0);
      rdc(8'h84, 32'h0000_40C3);
      // Node closes the frame only when it sees the sync pause
      repeat (100) @(posedge clk_in);
      check({24'h0, flen}, 32'h0000_0020);
      check({31'h0, lost}, 32'h0);
      // Host scans a foreign channel first: node must stay silent
      wr(REG_CHAN, 32'h0000_0003);
      @(posedge clk_in);
      cfg_mux <= 1'b1;
      wr(REG_CTRL, 32'h0000_0009);
      wait_frame(2);
      rdc(8'h84, 32'h0);
      wr(REG_CHAN, 32'h0000_0005);
      wait_frame(2);
      rdc(8'h84, 32'h0000_40C3);
      @(posedge clk_in);
      cfg_mux <= 1'b0;
      cfg_ms  <= 1'b1;
      cfg_deb <= 1'b1;
      wr(REG_CTRL, 32'h0000_0003);
      wait_frame(1);
      wr(8'h40, 32'h0000_00A5);
      for (int i = 0; i < DEB_FRAMES; i++) begin
         wait_frame(1);
         repeat (100) @(posedge clk_in);
         check({24'h0, outs}, (i == DEB_FRAMES - 1) ? 32'h0000_00A5 : 32'h0);
      end
      rdc(8'h84, 32'h0000_40C3);
      @(posedge clk_in);
      cfg_deb <= 1'b0;
      cfg_inb <= 8'h00;
      ins     <= 8'h5A;
      wr(REG_CTRL, 32'h0000_0007);
      wait_frame(3);
      repeat (100) @(posedge clk_in);
      check({24'h0, outs}, 32'h0000_005A);
      wr(REG_IRQ_MASK, 32'h0);
      repeat (1600) @(posedge clk_in);
      rd(REG_IRQ_STAT, rv);
      check({31'h0, rv[IRQ_FRAME]}, 32'h1);
      check({31'h0, rv[IRQ_CHANGE]}, 32'h1);
      check({31'h0, irq}, 32'h0);
      wr(REG_IRQ_STAT, 32'h0000_0003);
      wr(REG_IRQ_MASK, 32'h0000_0001);
      wait_frame(1);
      // Stop in the sync pause so no partial frame is left on the bus
      wr(REG_CTRL, 32'h0);
      repeat (LOSS + 200) @(posedge clk_in);
      check({31'h0, lost}, 32'h1);
      check({24'h0, outs}, 32'h0);
      rdc(REG_STATUS, 32'h0000_1F00);
      results();
   end
endmodule // control_bus_io_node_tb_top
`default_nettype wire
